// File: shared/prsm_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the reference selector.
// Assumes: Eight-bit registers on the device register port.
// Notes:   Definitions only.
`ifndef PRSM_DEFINES_SVH
`define PRSM_DEFINES_SVH

`define PRSM_ADDR_W         10
`define PRSM_DATA_W         8
`define PRSM_MON_SEL_ADDR   10'h010
`define PRSM_STAT_SEL_ADDR  10'h017
`define PRSM_REF_CTRL_ADDR  10'h01C
`define PRSM_MISC_CTRL_ADDR 10'h01D

`define PRSM_MON_SEL_RST    8'h00
`define PRSM_STAT_SEL_RST   8'h00
`define PRSM_REF_CTRL_RST   8'h00
`define PRSM_MISC_CTRL_RST  8'h80

`define PRSM_BIT_DIFF       0
`define PRSM_BIT_PRI_PWR    1
`define PRSM_BIT_SEC_PWR    2
`define PRSM_BIT_STAY_SEC   3
`define PRSM_BIT_AUTO       4
`define PRSM_BIT_USE_PIN    5
`define PRSM_BIT_REG_SEC    6
`define PRSM_BIT_NO_DEGL    7
`define PRSM_BIT_XTAL_EN    6
`define PRSM_BIT_NV_STAT    7
`define PRSM_STAT_FLD_LSB   2

`define PRSM_SYNC_N         10

`endif

// File: shared/prsm_pkg.sv
// Purpose: Types of the reference selector.
// Assumes: Nothing.
// Notes:   One-hot codes for the automatic switchover state.
package prsm_pkg;
  typedef enum logic [1:0] {
    PRSM_ON_PRIMARY   = 2'b01,
    PRSM_ON_SECONDARY = 2'b10
  } prsm_auto_state_t;

  typedef logic [4:0] prsm_mon_code_t;
endpackage : prsm_pkg

// File: src/prsm_ref_select.sv
// Purpose: PLL reference selection, power gating, monitor and status pin multiplexers.
// Assumes: Register port is synchronous to clk_in; all other inputs are asynchronous.
// Notes:   Reference clocks are sampled at 50 MHz, so monitored clocks are seen at that rate.
// Summary of operation
// RQ1 - Monitor pin follows five-bit select, default ground.
// RQ2 - One monitor code drives constant high.
// RQ3 - Monitor passes primary, secondary, selected, unselected clocks.
// RQ4 - Secondary and unselected codes dead in differential.
// RQ5 - Active-low status codes for references and VCO.
// RQ6 - AND-of-status level codes on monitor.
// RQ7 - Inverted active-reference indication code.
// RQ8 - Active-low holdover, comparator, lock detect codes.
// RQ9 - Bit 7 low enables switchover deglitch.
// RQ10 - Bit 4 picks manual or automatic switchover.
// RQ11 - Software picks single-ended before automatic mode.
// RQ12 - Automatic mode powers both references always.
// RQ13 - Bit 5 picks register or pin selection.
// RQ14 - Bit 6 picks primary or secondary reference.
// RQ15 - Bit 3 stops return to primary reference.
// RQ16 - Bit 2 powers secondary reference input.
// RQ17 - Bit 1 powers primary reference input.
// RQ18 - Bit 0 picks single-ended or differential mode.
// RQ19 - Software clears power bits in differential.
// RQ20 - Misc bit 7 forces load status on pin.
// RQ21 - Misc bit 6 enables crystal amplifier.
// RQ22 - Crystal amplifier off after reset.
`timescale 1ns/10ps
`include "prsm_defines.svh"

module prsm_ref_select (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  input  wire logic [`PRSM_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [`PRSM_DATA_W-1:0]  reg_wdata_in,
  input  wire logic                     primary_reference_in,
  input  wire logic                     secondary_reference_in,
  input  wire logic                     ref_select_pin_in,
  input  wire logic                     primary_freq_ok_in,
  input  wire logic                     secondary_freq_ok_in,
  input  wire logic                     vco_freq_ok_in,
  input  wire logic                     digital_lock_detect_in,
  input  wire logic                     holdover_active_in,
  input  wire logic                     lock_detect_pin_cmp_in,
  input  wire logic                     nv_load_status_in,
  output logic [`PRSM_DATA_W-1:0]       reg_rdata_out,
  output logic                          reference_monitor_pin_out,
  output logic                          status_pin_out,
  output logic                          pll_reference_out,
  output logic                          selected_is_secondary_out,
  output logic                          primary_ref_power_out,
  output logic                          secondary_ref_power_out,
  output logic                          differential_mode_out,
  output logic                          crystal_amp_enable_out,
  output prsm_pkg::prsm_auto_state_t    auto_state_out
);
  import prsm_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [`PRSM_SYNC_N-1:0] sync_stage1;
  logic [`PRSM_SYNC_N-1:0] sync_stage2;
  wire  [`PRSM_SYNC_N-1:0] raw_inputs;

  assign raw_inputs = {nv_load_status_in, lock_detect_pin_cmp_in, holdover_active_in,
                       digital_lock_detect_in, vco_freq_ok_in, secondary_freq_ok_in,
                       primary_freq_ok_in, ref_select_pin_in, secondary_reference_in,
                       primary_reference_in};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_stage1 <= '0;
      sync_stage2 <= '0;
    end else begin
      sync_stage1 <= raw_inputs;
      sync_stage2 <= sync_stage1;
    end
  end

  wire pri_clk  = sync_stage2[0];
  wire sec_clk  = sync_stage2[1];
  wire sel_pin  = sync_stage2[2];
  wire pri_ok   = sync_stage2[3];
  wire sec_ok   = sync_stage2[4];
  wire vco_ok   = sync_stage2[5];
  wire digital_lock_detect      = sync_stage2[6];
  wire holdover = sync_stage2[7];
  wire ld_cmp   = sync_stage2[8];
  wire nv_stat  = sync_stage2[9];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`PRSM_DATA_W-1:0] mon_sel_reg;
  logic [`PRSM_DATA_W-1:0] stat_sel_reg;
  logic [`PRSM_DATA_W-1:0] ref_ctrl;
  logic [`PRSM_DATA_W-1:0] misc_ctrl;
  logic [`PRSM_DATA_W-1:0] next_rdata;

  wire hit_mon  = (reg_addr_in == `PRSM_MON_SEL_ADDR);
  wire hit_stat = (reg_addr_in == `PRSM_STAT_SEL_ADDR);
  wire hit_ref  = (reg_addr_in == `PRSM_REF_CTRL_ADDR);
  wire hit_misc = (reg_addr_in == `PRSM_MISC_CTRL_ADDR);

  // Unmapped addresses read as zero.
  assign next_rdata = hit_mon  ? {3'h0, mon_sel_reg[4:0]} :
                      hit_stat ? {stat_sel_reg[7:2], 2'h0} :
                      hit_ref  ? ref_ctrl :
                      hit_misc ? misc_ctrl : 8'h00;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mon_sel_reg  <= `PRSM_MON_SEL_RST;
      stat_sel_reg <= `PRSM_STAT_SEL_RST;
      ref_ctrl     <= `PRSM_REF_CTRL_RST;
      misc_ctrl    <= `PRSM_MISC_CTRL_RST; // RQ22
    end else if (reg_wr_in) begin
      if (hit_mon)  mon_sel_reg  <= reg_wdata_in;
      if (hit_stat) stat_sel_reg <= reg_wdata_in;
      if (hit_ref)  ref_ctrl     <= reg_wdata_in;
      if (hit_misc) misc_ctrl    <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------
  wire diff_mode  = ref_ctrl[`PRSM_BIT_DIFF];     // RQ18
  wire auto_mode  = ref_ctrl[`PRSM_BIT_AUTO];     // RQ10
  wire stay_sec   = ref_ctrl[`PRSM_BIT_STAY_SEC];
  wire use_pin    = ref_ctrl[`PRSM_BIT_USE_PIN];
  wire reg_sec    = ref_ctrl[`PRSM_BIT_REG_SEC];
  wire degl_on    = !ref_ctrl[`PRSM_BIT_NO_DEGL]; // RQ9
  wire nv_forced  = misc_ctrl[`PRSM_BIT_NV_STAT];

  // ----------------------------------------------------------------
  // Automatic switchover state
  // ----------------------------------------------------------------
  prsm_auto_state_t auto_state;
  prsm_auto_state_t next_auto_state;

  always_comb begin
    next_auto_state = auto_state;
    case (auto_state)
      PRSM_ON_PRIMARY: begin
        if (auto_mode && !pri_ok && sec_ok) begin // RQ10
          next_auto_state = PRSM_ON_SECONDARY;
        end
      end
      PRSM_ON_SECONDARY: begin
        if (!auto_mode) begin
          next_auto_state = PRSM_ON_PRIMARY;
        end else if (pri_ok && (!stay_sec || !sec_ok)) begin // RQ15
          next_auto_state = PRSM_ON_PRIMARY;
        end
      end
      default: begin
        next_auto_state = PRSM_ON_PRIMARY;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_state <= PRSM_ON_PRIMARY;
    end else begin
      auto_state <= next_auto_state;
    end
  end

  // ----------------------------------------------------------------
  // Reference selection with deglitch
  // ----------------------------------------------------------------
  logic sel_secondary;
  wire  manual_want = use_pin ? sel_pin : reg_sec;                  // RQ13 RQ14
  wire  want_sec    = diff_mode ? 1'b0 :
                      auto_mode ? (auto_state == PRSM_ON_SECONDARY) : manual_want;
  // Deglitch waits for both references low so the PLL never sees a runt pulse.
  // A reference stuck high therefore holds off the switch while deglitch is on.
  wire  both_low    = !pri_clk && !sec_clk;
  wire  commit_sel  = !degl_on || both_low;                         // RQ9

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_secondary <= 1'b0;
    end else if (commit_sel) begin
      sel_secondary <= want_sec;
    end
  end

  wire sel_clk   = sel_secondary ? sec_clk : pri_clk;
  wire unsel_clk = diff_mode ? 1'b0 : (sel_secondary ? pri_clk : sec_clk); // RQ4
  wire sec_mon   = diff_mode ? 1'b0 : sec_clk;                              // RQ4
  wire sel_ok    = sel_secondary ? sec_ok : pri_ok;
  wire unsel_ok  = diff_mode ? 1'b0 : (sel_secondary ? pri_ok : sec_ok);
  wire unsel_okn = diff_mode ? 1'b0 : !unsel_ok;
  wire both_ok   = pri_ok && sec_ok;
  wire all_lock  = digital_lock_detect && sel_ok && vco_ok;

  // ----------------------------------------------------------------
  // Monitor multiplexer
  // ----------------------------------------------------------------
  // Bit n shows what monitor code n selects; the status pin reuses the same table.
  // A plain vector keeps every source in the sensitivity of the selects below.
  wire [31:0] mon_src = {!ld_cmp, !holdover, !digital_lock_detect, !sel_secondary,     // RQ8 RQ7
                         !vco_ok, all_lock, both_ok, !sec_ok,           // RQ5 RQ6
                         !pri_ok, unsel_okn, !sel_ok, unsel_clk,        // RQ5 RQ4 RQ3
                         sel_clk, sec_mon, pri_clk, 1'b1,               // RQ3 RQ2
                         ld_cmp, holdover, !digital_lock_detect, sel_secondary,         // RQ8
                         vco_ok, all_lock, both_ok, sec_ok,             // RQ6
                         pri_ok, unsel_ok, sel_ok, unsel_clk,           // RQ4
                         sel_clk, sec_mon, pri_clk, 1'b0};              // RQ3 RQ1

  wire            mon_val   = mon_src[prsm_mon_code_t'(mon_sel_reg[4:0])]; // RQ1
  wire            stat_pick = mon_src[prsm_mon_code_t'(stat_sel_reg[6:2])];
  wire            stat_val  = nv_forced ? nv_stat : stat_pick;               // RQ20
  // Automatic mode forces both inputs on, whatever the power bits say.
  wire            pri_pwr   = auto_mode || ref_ctrl[`PRSM_BIT_PRI_PWR];      // RQ12 RQ17
  wire            sec_pwr   = auto_mode || ref_ctrl[`PRSM_BIT_SEC_PWR];      // RQ12 RQ16

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reference_monitor_pin_out <= 1'b0;
      status_pin_out            <= 1'b0;
      pll_reference_out         <= 1'b0;
      selected_is_secondary_out <= 1'b0;
      primary_ref_power_out     <= 1'b0;
      secondary_ref_power_out   <= 1'b0;
      differential_mode_out     <= 1'b0;
      crystal_amp_enable_out    <= 1'b0; // RQ22
      auto_state_out            <= PRSM_ON_PRIMARY;
    end else begin
      reference_monitor_pin_out <= mon_val;
      status_pin_out            <= stat_val;
      pll_reference_out         <= sel_clk;
      selected_is_secondary_out <= sel_secondary;
      primary_ref_power_out     <= pri_pwr;
      secondary_ref_power_out   <= sec_pwr;
      differential_mode_out     <= diff_mode;
      crystal_amp_enable_out    <= misc_ctrl[`PRSM_BIT_XTAL_EN]; // RQ21
      auto_state_out            <= auto_state;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_misc_write;
    reg_wr_in && hit_misc;
  endsequence

  property p_xtal_follows_write;
    s_misc_write |-> ##2 (crystal_amp_enable_out == $past(reg_wdata_in[`PRSM_BIT_XTAL_EN], 2));
  endproperty
  a_xtal_follows_write: assert property (p_xtal_follows_write) else $error("Crystal enable wrong."); // RQ21

  property p_ground_default;
    (mon_sel_reg[4:0] == 5'h00) |=> !reference_monitor_pin_out;
  endproperty
  a_ground_default: assert property (p_ground_default) else $error("Monitor not grounded."); // RQ1

  property p_supply_high;
    (mon_sel_reg[4:0] == 5'h10) |=> reference_monitor_pin_out;
  endproperty
  a_supply_high: assert property (p_supply_high) else $error("Monitor not high."); // RQ2

  property p_diff_unavailable;
    (diff_mode && (mon_sel_reg[3:0] == 4'h2 || mon_sel_reg[3:0] == 4'h4)) |=> !reference_monitor_pin_out;
  endproperty
  a_diff_unavailable: assert property (p_diff_unavailable) else $error("Secondary seen in diff mode."); // RQ4

  property p_sel_status_low;
    (mon_sel_reg[4:0] == 5'h15) |=> (reference_monitor_pin_out != $past(sel_ok));
  endproperty
  a_sel_status_low: assert property (p_sel_status_low) else $error("Status not inverted."); // RQ5

  property p_all_lock;
    (mon_sel_reg[4:0] == 5'h1A) |=> (reference_monitor_pin_out == $past(digital_lock_detect && vco_ok && sel_ok));
  endproperty
  a_all_lock: assert property (p_all_lock) else $error("Lock AND wrong."); // RQ6

  property p_active_ref;
    (mon_sel_reg[4:0] == 5'h1C) |=> (reference_monitor_pin_out == !selected_is_secondary_out);
  endproperty
  a_active_ref: assert property (p_active_ref) else $error("Active reference sense wrong."); // RQ7

  property p_holdover_low;
    (mon_sel_reg[4:0] == 5'h1E) |=> (reference_monitor_pin_out == !$past(holdover));
  endproperty
  a_holdover_low: assert property (p_holdover_low) else $error("Holdover not inverted."); // RQ8

  property p_deglitch_hold;
    (degl_on && !both_low) |=> $stable(sel_secondary);
  endproperty
  a_deglitch_hold: assert property (p_deglitch_hold) else $error("Switch during high clock."); // RQ9

  sequence s_primary_fails;
    auto_mode && !diff_mode && auto_state == PRSM_ON_PRIMARY && !pri_ok && sec_ok;
  endsequence

  property p_auto_switch;
    s_primary_fails |=> (auto_state == PRSM_ON_SECONDARY) ##1 (auto_state_out == PRSM_ON_SECONDARY);
  endproperty
  a_auto_switch: assert property (p_auto_switch) else $error("No automatic switch."); // RQ10

  property p_auto_power;
    auto_mode |=> (primary_ref_power_out && secondary_ref_power_out);
  endproperty
  a_auto_power: assert property (p_auto_power) else $error("Auto mode left a reference off."); // RQ12

  property p_manual_power;
    !auto_mode |=> (primary_ref_power_out == $past(ref_ctrl[1]) && secondary_ref_power_out == $past(ref_ctrl[2]));
  endproperty
  a_manual_power: assert property (p_manual_power) else $error("Power bits ignored."); // RQ16

  property p_manual_select;
    (!auto_mode && !diff_mode && commit_sel) |=> (sel_secondary == $past(use_pin ? sel_pin : reg_sec));
  endproperty
  a_manual_select: assert property (p_manual_select) else $error("Manual selection wrong."); // RQ13

  property p_revert;
    (auto_mode && auto_state == PRSM_ON_SECONDARY && pri_ok && !stay_sec) |=> (auto_state == PRSM_ON_PRIMARY);
  endproperty
  a_revert: assert property (p_revert) else $error("No return to primary."); // RQ15

  property p_stay;
    (auto_mode && auto_state == PRSM_ON_SECONDARY && stay_sec && sec_ok) |=> (auto_state == PRSM_ON_SECONDARY);
  endproperty
  a_stay: assert property (p_stay) else $error("Left secondary."); // RQ15

  property p_diff_primary;
    (diff_mode && commit_sel) |=> !sel_secondary;
  endproperty
  a_diff_primary: assert property (p_diff_primary) else $error("Diff mode on secondary."); // RQ18

  property p_status_override;
    nv_forced |=> (status_pin_out == $past(nv_stat));
  endproperty
  a_status_override: assert property (p_status_override) else $error("Status override lost."); // RQ20

endmodule : prsm_ref_select

// File: bench/prsm_ref_source.sv
// Purpose: Far-side model: two reference clock sources and the select pin.
// Assumes: Half periods are unrelated to the 20 ns system clock.
// Notes:   A stopped clock rests at the level the bench asks for.
`timescale 1ns/10ps

module prsm_ref_source #(
  parameter int PRI_HALF_NS = 47,
  parameter int SEC_HALF_NS = 65
) (
  input  wire logic run_in,
  input  wire logic pri_lvl_in,
  input  wire logic sec_lvl_in,
  input  wire logic pin_lvl_in,
  output logic      pri_out,
  output logic      sec_out,
  output logic      sel_pin_out
);
  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  // Resting at a chosen level lets the bench compare clock codes exactly.
  always begin
    if (run_in) #(PRI_HALF_NS) pri_out = ~pri_out;
    else begin
      pri_out = pri_lvl_in;
      @(run_in or pri_lvl_in);
    end
  end

  always begin
    if (run_in) #(SEC_HALF_NS) sec_out = ~sec_out;
    else begin
      sec_out = sec_lvl_in;
      @(run_in or sec_lvl_in);
    end
  end

  assign sel_pin_out = pin_lvl_in;
endmodule : prsm_ref_source

// File: bench/pll_reference_select_and_monitor_tb.sv
// Purpose: Self-checking bench of the reference selector against a behavioural model.
// Assumes: Outputs settle within ten cycles of any input or register change.
// Notes:   Clocks are stopped at fixed levels except in the deglitch scenario.
`timescale 1ns/10ps
`include "prsm_defines.svh"

module pll_reference_select_and_monitor_tb;
  import prsm_pkg::*;
  logic              clk_in, rst_in, wr_en, rd, run, p_lvl, s_lvl, pin_lvl;
  logic              pri_ok, sec_ok, vco, digital_lock_detect, hold, cmp, nv;
  logic [9:0]        addr;
  logic [7:0]        wdata, rdata, m_mon, m_stat, m_ref, m_misc;
  logic              pri_clk, sec_clk, sel_pin, auto_sec;
  logic              mon_pin, stat_pin, pll_ref, sel_sec, pri_pwr, sec_pwr, diff_o, xtal;
  prsm_auto_state_t  auto_st;
  logic [31:0]       seed;
  int                miscompares, checks;

  prsm_ref_source i_prsm_ref_source (.run_in(run), .pri_lvl_in(p_lvl), .sec_lvl_in(s_lvl),
    .pin_lvl_in(pin_lvl), .pri_out(pri_clk), .sec_out(sec_clk), .sel_pin_out(sel_pin));

  prsm_ref_select i_prsm_ref_select (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr_en), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .primary_reference_in(pri_clk),
    .secondary_reference_in(sec_clk), .ref_select_pin_in(sel_pin), .primary_freq_ok_in(pri_ok),
    .secondary_freq_ok_in(sec_ok), .vco_freq_ok_in(vco), .digital_lock_detect_in(digital_lock_detect),
    .holdover_active_in(hold), .lock_detect_pin_cmp_in(cmp), .nv_load_status_in(nv),
    .reg_rdata_out(rdata), .reference_monitor_pin_out(mon_pin), .status_pin_out(stat_pin),
    .pll_reference_out(pll_ref), .selected_is_secondary_out(sel_sec), .primary_ref_power_out(pri_pwr),
    .secondary_ref_power_out(sec_pwr), .differential_mode_out(diff_o),
    .crystal_amp_enable_out(xtal), .auto_state_out(auto_st));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Model
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  function automatic logic sel_exp();
    if (m_ref[0]) return 1'b0;
    if (m_ref[4]) return auto_sec;
    return m_ref[5] ? pin_lvl : m_ref[6];
  endfunction : sel_exp

  function automatic logic mon_exp(input logic [4:0] c);
    logic ss, sok, uok, lo, d;
    ss = sel_exp();
    d = m_ref[0];
    lo = c[4];
    sok = ss ? sec_ok : pri_ok;
    uok = ss ? pri_ok : sec_ok;
    case (c[3:0])
      4'h0: return lo;
      4'h1: return p_lvl;
      4'h2: return d ? 1'b0 : s_lvl;
      4'h3: return ss ? s_lvl : p_lvl;
      4'h4: return d ? 1'b0 : (ss ? p_lvl : s_lvl);
      4'h5: return sok ^ lo;
      4'h6: return d ? 1'b0 : (uok ^ lo);
      4'h7: return pri_ok ^ lo;
      4'h8: return sec_ok ^ lo;
      4'h9: return pri_ok & sec_ok;
      4'hA: return digital_lock_detect & sok & vco;
      4'hB: return vco ^ lo;
      4'hC: return ss ^ lo;
      4'hD: return ~digital_lock_detect;
      4'hE: return hold ^ lo;
      default: return cmp ^ lo;
    endcase
  endfunction : mon_exp

  function automatic void step_auto();
    if (!m_ref[4]) auto_sec = 1'b0;
    else if (!auto_sec) auto_sec = !pri_ok && sec_ok;
    else if (pri_ok && (!m_ref[3] || !sec_ok)) auto_sec = 1'b0;
  endfunction : step_auto

  function automatic logic [7:0] reg_exp(input logic [9:0] a);
    case (a)
      `PRSM_MON_SEL_ADDR:   return m_mon;
      `PRSM_STAT_SEL_ADDR:  return m_stat;
      `PRSM_REF_CTRL_ADDR:  return m_ref;
      `PRSM_MISC_CTRL_ADDR: return m_misc;
      default:              return 8'h00;
    endcase
  endfunction : reg_exp

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_in);
    wr_en = 1'b0;
    case (a)
      `PRSM_MON_SEL_ADDR:   m_mon = d & 8'h1F;
      `PRSM_STAT_SEL_ADDR:  m_stat = d & 8'hFC;
      `PRSM_REF_CTRL_ADDR:  m_ref = d;
      `PRSM_MISC_CTRL_ADDR: m_misc = d;
      default: ;
    endcase
  endtask : wr

  task automatic rd_all();
    logic [9:0] al[6] = '{`PRSM_MON_SEL_ADDR, `PRSM_STAT_SEL_ADDR, `PRSM_REF_CTRL_ADDR,
                          `PRSM_MISC_CTRL_ADDR, 10'h011, 10'h020};
    foreach (al[i]) begin
      @(negedge clk_in);
      rd = 1'b1;
      addr = al[i];
      @(negedge clk_in);
      rd = 1'b0;
      chk("rdata", reg_exp(al[i]), rdata);
    end
  endtask : rd_all

  task automatic settle();
    repeat (10) @(negedge clk_in);
    step_auto();
  endtask : settle

  task automatic check_all();
    chk("mon", {7'h00, mon_exp(m_mon[4:0])}, {7'h00, mon_pin});
    chk("status", {7'h00, m_misc[7] ? nv : mon_exp(m_stat[6:2])}, {7'h00, stat_pin});
    chk("sel_sec", {7'h00, sel_exp()}, {7'h00, sel_sec});
    chk("pll_ref", {7'h00, sel_exp() ? s_lvl : p_lvl}, {7'h00, pll_ref});
    chk("pri_pwr", {7'h00, m_ref[4] | m_ref[1]}, {7'h00, pri_pwr});
    chk("sec_pwr", {7'h00, m_ref[4] | m_ref[2]}, {7'h00, sec_pwr});
    chk("diff", {7'h00, m_ref[0]}, {7'h00, diff_o});
    chk("xtal", {7'h00, m_misc[6]}, {7'h00, xtal});
    chk("auto", {6'h00, auto_sec ? PRSM_ON_SECONDARY : PRSM_ON_PRIMARY}, {6'h00, auto_st});
  endtask : check_all

  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // About 2200 cycles are needed; the limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    print_verdict();
  end

  initial begin
    logic [7:0] nr;
    {wr_en, rd, addr, wdata, run, p_lvl, s_lvl, pin_lvl} = '0;
    {pri_ok, sec_ok, vco, digital_lock_detect, hold, cmp, nv} = 7'h7F;
    {m_mon, m_stat, m_ref, m_misc} = 32'h00000080;
    {auto_sec, miscompares, checks} = '0;
    seed = 32'h15D6;
    rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    settle();
    check_all();
    rd_all();
    wr(`PRSM_MON_SEL_ADDR, 8'hFF);
    wr(`PRSM_STAT_SEL_ADDR, 8'hFF);
    wr(10'h020, 8'h5A);
    rd_all();
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 32; c++) begin
        seed = lfsr(seed);
        {pri_ok, sec_ok, vco, digital_lock_detect, hold, cmp, nv, pin_lvl, p_lvl, s_lvl} = seed[9:0];
        wr(`PRSM_REF_CTRL_ADDR, d ? 8'h81 : (8'h80 | (seed[23:16] & 8'h60)));
        wr(`PRSM_MON_SEL_ADDR, {3'h0, c[4:0]});
        wr(`PRSM_STAT_SEL_ADDR, {1'b0, c[4:0] ^ 5'h05, 2'b00});
        wr(`PRSM_MISC_CTRL_ADDR, 8'h00);
        settle();
        check_all();
      end
    end
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(lfsr(seed));
      {pri_ok, sec_ok, vco, digital_lock_detect, hold, cmp, nv, pin_lvl, p_lvl, s_lvl} = seed[9:0];
      settle();
      nr = (seed[23:16] | 8'h80) & 8'hFE;
      wr(`PRSM_REF_CTRL_ADDR, nr);
      wr(`PRSM_MON_SEL_ADDR, seed[31:24]);
      wr(`PRSM_STAT_SEL_ADDR, seed[15:8]);
      wr(`PRSM_MISC_CTRL_ADDR, seed[11:4]);
      settle();
      check_all();
    end
    wr(`PRSM_MISC_CTRL_ADDR, 8'h40);
    for (int s = 0; s < 2; s++) begin
      pri_ok = 1'b0;
      sec_ok = 1'b1;
      wr(`PRSM_REF_CTRL_ADDR, 8'h90 | {4'h0, s[0], 3'b000});
      settle();
      check_all();
      pri_ok = 1'b1;
      settle();
      check_all();
      wr(`PRSM_REF_CTRL_ADDR, 8'h80);
      settle();
      check_all();
    end
    p_lvl = 1'b1;
    s_lvl = 1'b0;
    wr(`PRSM_REF_CTRL_ADDR, 8'h40);
    settle();
    chk("sel_sec", 8'h00, {7'h00, sel_sec});
    wr(`PRSM_REF_CTRL_ADDR, 8'hC0);
    settle();
    chk("sel_sec", 8'h01, {7'h00, sel_sec});
    wr(`PRSM_REF_CTRL_ADDR, 8'h00);
    run = 1'b1;
    for (int k = 0; k < 200 && sel_sec !== 1'b0; k++) @(negedge clk_in);
    chk("sel_sec", 8'h00, {7'h00, sel_sec});
    run = 1'b0;
    settle();
    check_all();
    print_verdict();
  end
endmodule : pll_reference_select_and_monitor_tb
